/* shared/bpr_pkg.sv */
// Constants shared by the backplane receive path, its decoder and its encoder.
// Assumes one interface clock toward the link and one bus-side clock.
package bpr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Link interface codes
  localparam logic [1:0] CTL_IDLE    = 2'h0;
  localparam logic [1:0] CTL_STATUS  = 2'h1;
  localparam logic [1:0] CTL_RECEIVE = 2'h2;
  localparam logic [3:0] D_ALL_HIGH  = 4'hf;
  localparam logic [1:0] SPEED_CODE  = 2'h0;
  localparam logic [1:0] D_UPPER_LOW = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Bus side
  localparam logic [2:0] GROUP_SLOW   = 3'h2;
  localparam logic [2:0] GROUP_FAST   = 3'h4;
  localparam logic [2:0] IDLE_END     = 3'h4;
  localparam int         ARB_CLK_KHZ  = 49152;
  localparam int         SLOW_KBPS    = 49152;
  localparam int         FAST_KBPS    = 98304;
  localparam int         MAX_NODES    = 63;

  // Messages carried from the bus domain to the link domain
  typedef enum logic [1:0] {
    MSG_START,
    MSG_DATA,
    MSG_END,
    MSG_END_DATA
  } bpr_msg_t;

  // Pin drive for one open-collector line: {level, oe_n}
  function automatic logic [1:0] pin_drive(input logic lvl, input logic pp);
    pin_drive = lvl ? 2'h0 : (pp ? 2'h2 : 2'h1);
  endfunction

endpackage

/* logic/bpr_ds_decoder.sv */
// Data-strobe receive decoder on the bus clock.
// Assumes the bus clock is several times the bit rate and reset is synchronous-released.
module bpr_ds_decoder (
  // Clock and reset
  input  wire logic           i_bus_clk,
  input  wire logic           i_bus_resetn,
  // Backplane receive lines, logical levels
  input  wire logic           i_rx_bus_data,
  input  wire logic           i_rx_bus_strobe,
  input  wire logic           i_fast_rate,
  // Message toward the link domain
  output logic                o_msg_tog,
  output bpr_pkg::bpr_msg_t   o_msg_kind,
  output logic [3:0]          o_msg_data
);

  logic [2:0] sd;
  logic [2:0] ss;
  logic [2:0] sf;
  logic       filt_d;
  logic       filt_s;
  logic       fast;
  logic       par_q;
  logic       active;
  logic [2:0] idle_cnt;
  logic [2:0] cnt;
  logic [3:0] sh;

  // A change counts only once the second and third stages agree
  always_ff @(posedge i_bus_clk or negedge i_bus_resetn)
  begin
    if (!i_bus_resetn)
    begin
      sd <= 3'h0;
      ss <= 3'h0;
      sf <= 3'h0;
      filt_d <= 1'h0;
      filt_s <= 1'h0;
      fast <= 1'h0;
      par_q <= 1'h0;
    end
    else
    begin
      sd <= {sd[1:0], i_rx_bus_data};
      ss <= {ss[1:0], i_rx_bus_strobe};
      sf <= {sf[1:0], i_fast_rate};
      if (sd[1] == sd[2]) filt_d <= sd[2];
      if (ss[1] == ss[2]) filt_s <= ss[2];
      if (sf[1] == sf[2]) fast <= sf[2];
      par_q <= filt_d ^ filt_s;
    end
  end

  wire       bit_edge = (filt_d ^ filt_s) != par_q;
  wire [2:0] grp      = fast ? bpr_pkg::GROUP_FAST : bpr_pkg::GROUP_SLOW;
  wire [3:0] placed   = filt_d ? (4'h1 << cnt[1:0]) : 4'h0;
  wire       full     = bit_edge && active && (cnt + 3'h1 == grp);
  wire       timeout  = !bit_edge && active && (idle_cnt == bpr_pkg::IDLE_END - 3'h1);

  always_ff @(posedge i_bus_clk or negedge i_bus_resetn)
  begin
    if (!i_bus_resetn)
    begin
      active <= 1'h0;
      idle_cnt <= 3'h0;
      cnt <= 3'h0;
      sh <= 4'h0;
      o_msg_tog <= 1'h0;
      o_msg_kind <= bpr_pkg::MSG_END;
      o_msg_data <= 4'h0;
    end
    else if (bit_edge)
    begin
      idle_cnt <= 3'h0;
      active <= 1'h1;
      sh <= full ? 4'h0 : (sh | placed);
      cnt <= full ? 3'h0 : cnt + 3'h1;
      if (!active || full)
      begin
        o_msg_tog <= ~o_msg_tog;
        o_msg_kind <= active ? bpr_pkg::MSG_DATA : bpr_pkg::MSG_START;
        o_msg_data <= sh | placed;
      end
    end
    else if (timeout)
    begin
      active <= 1'h0;
      idle_cnt <= 3'h0;
      cnt <= 3'h0;
      sh <= 4'h0;
      o_msg_tog <= ~o_msg_tog;
      o_msg_kind <= (cnt != 3'h0) ? bpr_pkg::MSG_END_DATA : bpr_pkg::MSG_END;
      o_msg_data <= sh;
    end
    else if (active)
      idle_cnt <= idle_cnt + 3'h1;
  end

  a_group_order: assert property (@(posedge i_bus_clk) disable iff (!i_bus_resetn)
    full |=> o_msg_kind == bpr_pkg::MSG_DATA && o_msg_tog != $past(o_msg_tog) && cnt == 3'h0)
    else $error("full bit group not sent as data");

endmodule // bpr_ds_decoder

/* logic/bpr_ds_encoder.sv */
// Data-strobe transmit encoder and open-collector pin drive.
// Assumes one bit per bus clock; the bus clock is the arbitration clock.
module bpr_ds_encoder (
  // Clock and reset
  input  wire logic i_bus_clk,
  input  wire logic i_bus_resetn,
  // Bit source, bus clock domain
  input  wire logic i_tx_valid,
  input  wire logic i_tx_bit,
  input  wire logic i_arb_phase,
  input  wire logic i_push_pull,
  // Backplane pins
  output logic      o_tx_bus_data,
  output logic      o_tx_bus_data_oe_n,
  output logic      o_tx_bus_strobe,
  output logic      o_tx_bus_strobe_oe_n
);

  logic d_q;
  logic s_q;

  wire       next_d  = i_tx_valid ? i_tx_bit : d_q;
  wire       next_s  = (i_tx_valid && i_tx_bit == d_q) ? ~s_q : s_q;
  // Totem-pole release only outside arbitration; one stage per module
  wire       pp      = i_push_pull && !i_arb_phase;
  wire [1:0] drv_d   = bpr_pkg::pin_drive(next_d, pp);
  wire [1:0] drv_s   = bpr_pkg::pin_drive(next_s, pp);

  always_ff @(posedge i_bus_clk or negedge i_bus_resetn)
  begin
    if (!i_bus_resetn)
    begin
      d_q <= 1'h0;
      s_q <= 1'h0;
      o_tx_bus_data <= 1'h0;
      o_tx_bus_data_oe_n <= 1'h1;
      o_tx_bus_strobe <= 1'h0;
      o_tx_bus_strobe_oe_n <= 1'h1;
    end
    else
    begin
      d_q <= next_d;
      s_q <= next_s;
      {o_tx_bus_data, o_tx_bus_data_oe_n} <= drv_d;
      {o_tx_bus_strobe, o_tx_bus_strobe_oe_n} <= drv_s;
    end
  end

  a_ds_one_toggle: assert property (@(posedge i_bus_clk) disable iff (!i_bus_resetn)
    i_tx_valid |=> (d_q != $past(d_q)) != (s_q != $past(s_q)))
    else $error("data-strobe cell did not toggle exactly one line");

  a_one_sinks: assert property (@(posedge i_bus_clk) disable iff (!i_bus_resetn)
    d_q |-> !o_tx_bus_data && !o_tx_bus_data_oe_n)
    else $error("logic one not sinking the data line");

  a_arb_wired_or: assert property (@(posedge i_bus_clk) disable iff (!i_bus_resetn)
    $past(i_arb_phase) && !s_q |-> o_tx_bus_strobe_oe_n)
    else $error("strobe driven released level during arbitration");

endmodule // bpr_ds_encoder

/* logic/bpr_rx_path.sv */
// Backplane receive path toward the link, with status transfer and transmit pins.
// Assumes i_ref_clk is the link interface clock and i_bus_clk the bus-side clock.
module bpr_rx_path (
  // Clocks and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_bus_clk,
  // Backplane receive lines, logical levels
  input  wire logic       i_rx_bus_data,
  input  wire logic       i_rx_bus_strobe,
  input  wire logic       i_fast_rate,
  // Backplane transmit source, bus clock domain
  input  wire logic       i_tx_valid,
  input  wire logic       i_tx_bit,
  input  wire logic       i_arb_phase,
  input  wire logic       i_push_pull,
  // Backplane transmit pins
  output logic            o_tx_bus_data,
  output logic            o_tx_bus_data_oe_n,
  output logic            o_tx_bus_strobe,
  output logic            o_tx_bus_strobe_oe_n,
  // Status request, interface clock domain
  input  wire logic       i_status_req,
  input  wire logic [3:0] i_status_bits,
  output logic            o_status_pending,
  // Link interface
  output logic [1:0]      o_link_control_pair,
  output logic [3:0]      o_link_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus domain reset release

  logic [1:0] bus_rs;
  wire        bus_resetn = bus_rs[1];

  always_ff @(posedge i_bus_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      bus_rs <= 2'h0;
    else
      bus_rs <= {bus_rs[0], 1'h1};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus side logic

  logic              msg_tog;
  bpr_pkg::bpr_msg_t bus_kind;
  logic [3:0]        bus_data;

  bpr_ds_decoder u_dec (
    .i_bus_clk       (i_bus_clk),
    .i_bus_resetn    (bus_resetn),
    .i_rx_bus_data   (i_rx_bus_data),
    .i_rx_bus_strobe (i_rx_bus_strobe),
    .i_fast_rate     (i_fast_rate),
    .o_msg_tog       (msg_tog),
    .o_msg_kind      (bus_kind),
    .o_msg_data      (bus_data)
  );

  bpr_ds_encoder u_enc (
    .i_bus_clk            (i_bus_clk),
    .i_bus_resetn         (bus_resetn),
    .i_tx_valid           (i_tx_valid),
    .i_tx_bit             (i_tx_bit),
    .i_arb_phase          (i_arb_phase),
    .i_push_pull          (i_push_pull),
    .o_tx_bus_data        (o_tx_bus_data),
    .o_tx_bus_data_oe_n   (o_tx_bus_data_oe_n),
    .o_tx_bus_strobe      (o_tx_bus_strobe),
    .o_tx_bus_strobe_oe_n (o_tx_bus_strobe_oe_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Message crossing
  // The kind and data words are held in the bus domain from the toggle on,
  // so they are stable by the time the synchronised toggle is seen. There
  // is no return path: messages must be spaced by at least four link clocks.

  logic [2:0]        tsync;
  logic              tseen;
  logic              msg_v;
  bpr_pkg::bpr_msg_t msg_kind;
  logic [3:0]        msg_data;

  wire new_msg = (tsync[1] == tsync[2]) && (tsync[2] != tseen);

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      tsync <= 3'h0;
      tseen <= 1'h0;
      msg_kind <= bpr_pkg::MSG_END;
      msg_data <= 4'h0;
    end
    else
    begin
      tsync <= {tsync[1:0], msg_tog};
      if (tsync[1] == tsync[2])
        tseen <= tsync[2];
      if (new_msg)
      begin
        msg_kind <= bus_kind;
        msg_data <= bus_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link interface sequencer

  typedef enum logic [2:0] {
    R_IDLE,
    R_PREP,
    R_SPEED,
    R_DATA,
    R_LAST,
    R_STAT0,
    R_STAT1,
    R_GAP
  } bpr_rx_st_t;

  bpr_rx_st_t st;
  bpr_rx_st_t next_st;
  logic [3:0] stat_bits;
  logic       stat_pend;

  // States that own the link lines for a packet or for a status transfer
  function automatic logic rx_owned(input bpr_rx_st_t s);
    rx_owned = (s == R_PREP) || (s == R_SPEED) || (s == R_DATA) || (s == R_LAST);
  endfunction

  function automatic logic stat_owned(input bpr_rx_st_t s);
    stat_owned = (s == R_STAT0) || (s == R_STAT1);
  endfunction

  // Messages wait while the preamble and speed code go out
  wire in_stat  = stat_owned(st);
  wire take     = msg_v && (st != R_PREP) && (st != R_SPEED) && (st != R_LAST);
  wire is_start = take && (msg_kind == bpr_pkg::MSG_START);
  wire is_data  = take && (msg_kind == bpr_pkg::MSG_DATA);
  wire is_end   = take && (msg_kind == bpr_pkg::MSG_END);
  wire is_endd  = take && (msg_kind == bpr_pkg::MSG_END_DATA);
  wire stat_done = (st == R_STAT1) && !is_start;

  always_comb
  begin
    next_st = st;
    unique case (st)
      R_IDLE:  next_st = is_start ? R_PREP : (stat_pend ? R_STAT0 : R_IDLE);
      R_PREP:  next_st = R_SPEED;
      R_SPEED: next_st = R_DATA;
      R_DATA:  next_st = is_endd ? R_LAST : (is_end ? R_GAP : R_DATA);
      R_LAST:  next_st = R_GAP;
      R_STAT0: next_st = is_start ? R_PREP : R_STAT1;
      R_STAT1: next_st = is_start ? R_PREP : R_GAP;
      R_GAP:   next_st = is_start ? R_PREP : R_IDLE;
    endcase
  end

  // A data message shows its bits for one clock; apart from the speed code and status pairs, lines rest high
  wire rx_ctl = rx_owned(next_st);
  wire st_ctl = stat_owned(next_st);

  wire [1:0] next_ctl = rx_ctl ? bpr_pkg::CTL_RECEIVE :
                        (st_ctl ? bpr_pkg::CTL_STATUS : bpr_pkg::CTL_IDLE);

  wire [3:0] next_d =
    (next_st == R_SPEED) ? {bpr_pkg::D_UPPER_LOW, bpr_pkg::SPEED_CODE} :
    (rx_ctl && (is_data || is_endd)) ? msg_data :
    (next_st == R_STAT0) ? {2'h0, stat_bits[1:0]} :
    (next_st == R_STAT1) ? {2'h0, stat_bits[3:2]} :
    bpr_pkg::D_ALL_HIGH;

  wire next_pend = i_status_req || (stat_pend && !stat_done);

  // A new request in the finishing cycle keeps the transfer pending
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      stat_bits <= 4'h0;
      stat_pend <= 1'h0;
      o_status_pending <= 1'h0;
    end
    else
    begin
      if (i_status_req)
        stat_bits <= i_status_bits;
      stat_pend <= next_pend;
      o_status_pending <= next_pend;
    end
  end

  // A message waits in msg_v until the sequencer may take it
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st <= R_IDLE;
      msg_v <= 1'h0;
    end
    else
    begin
      st <= next_st;
      msg_v <= new_msg || (msg_v && !take);
    end
  end

  // Link lines are registered so the link samples settled levels
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_link_control_pair <= bpr_pkg::CTL_IDLE;
      o_link_data <= bpr_pkg::D_ALL_HIGH;
    end
    else
    begin
      o_link_control_pair <= next_ctl;
      o_link_data <= next_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_prep_all_high: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    st == R_PREP |-> o_link_control_pair == bpr_pkg::CTL_RECEIVE &&
      o_link_data == bpr_pkg::D_ALL_HIGH ##1 st == R_SPEED)
    else $error("receive preamble not all high");

  a_speed_code: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    st == R_SPEED |-> o_link_data[1:0] == bpr_pkg::SPEED_CODE ##1 st == R_DATA)
    else $error("speed code missing at packet start");

  a_rx_ctl_hold: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    st == R_DATA || st == R_LAST |-> o_link_control_pair == bpr_pkg::CTL_RECEIVE)
    else $error("receive state dropped during packet");

  a_end_idle: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    st == R_DATA && (is_end || is_endd) |-> ##[1:2]
      (st == R_GAP && o_link_control_pair == bpr_pkg::CTL_IDLE))
    else $error("idle not driven after packet end");

  a_status_yield: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    in_stat && is_start |=> o_link_control_pair == bpr_pkg::CTL_RECEIVE && stat_pend)
    else $error("status transfer not suspended for packet");

  a_stat_low_pair: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    st == R_STAT0 |-> o_link_control_pair == bpr_pkg::CTL_STATUS &&
      o_link_data[3:2] == bpr_pkg::D_UPPER_LOW)
    else $error("first status pair malformed");

  a_stat_high_pair: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    st == R_STAT1 |-> o_link_control_pair == bpr_pkg::CTL_STATUS &&
      o_link_data[3:2] == bpr_pkg::D_UPPER_LOW)
    else $error("second status pair malformed");

  a_stat_sequence: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    st == R_STAT0 && !is_start |=> st == R_STAT1)
    else $error("status transfer skipped its second pair");

  a_stat_resume: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    st == R_GAP && stat_pend && !is_start |=> st == R_IDLE ##1
      (st == R_STAT0 || st == R_PREP))
    else $error("pending status not resumed after the gap");

  a_stat_after_idle: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    st == R_STAT0 |-> $past(st) == R_IDLE)
    else $error("status transfer began without an idle cycle");

  a_stat_waits: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    stat_pend && rx_owned(st) |-> o_link_control_pair == bpr_pkg::CTL_RECEIVE)
    else $error("pending status displaced a packet");

  a_gap_idle: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    st == R_GAP |-> o_link_control_pair == bpr_pkg::CTL_IDLE && o_link_data == bpr_pkg::D_ALL_HIGH)
    else $error("gap cycle not idle");

  a_rest_high: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    st == R_IDLE |-> o_link_control_pair == bpr_pkg::CTL_IDLE && o_link_data == bpr_pkg::D_ALL_HIGH)
    else $error("link lines not resting high while idle");

  a_packet_start: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    st == R_IDLE && is_start |=> st == R_PREP)
    else $error("packet start not taken from idle");

  a_speed_lanes: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    st == R_SPEED |-> o_link_data[3:2] == bpr_pkg::D_UPPER_LOW)
    else $error("speed code upper lanes not low");

  a_data_shown: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    st == R_DATA && is_data |=> o_link_control_pair == bpr_pkg::CTL_RECEIVE &&
      o_link_data == $past(msg_data))
    else $error("data symbol not shown in the following cycle");

  a_last_shown: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    st == R_DATA && is_endd |=> st == R_LAST && o_link_data == $past(msg_data))
    else $error("closing bits not shown before idle");

  a_no_msg_loss: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    new_msg |-> !msg_v || take)
    else $error("bus message overwrote one still waiting");

endmodule // bpr_rx_path

/* verif/bpr_bus_src.sv */
// Far end of the backplane: a data-strobe coded bit source on the receive lines.
// Assumes the bus clock paces the cells; each bit cell lasts three bus clocks.
module bpr_bus_src (
  // Bus clock
  input  wire logic i_bus_clk,
  // Logical receive levels toward the block
  output logic      o_data,
  output logic      o_strobe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_data   = 1'b0;
    o_strobe = 1'b0;
  end

  // Levels persist between packets: falling back to released would add edges
  // that the receiver reads as bits, so gaps simply hold the last levels.
  task automatic send(input bit bits[$]);
    foreach (bits[i])
    begin
      @(posedge i_bus_clk);
      if (bits[i] != o_data)
        o_data <= bits[i];
      else
        o_strobe <= ~o_strobe;
      repeat (2) @(posedge i_bus_clk);
    end
  endtask
endmodule // bpr_bus_src

/* verif/tb.sv */
// Self-checking bench for the backplane receive path.
// Assumes the far end model drives the receive lines; fast grouping only.
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic       i_ref_clk     = 1'b0;
  logic       i_bus_clk     = 1'b0;
  logic       i_resetn      = 1'b0;
  logic       i_tx_valid    = 1'b0;
  logic       i_tx_bit      = 1'b0;
  logic       i_arb_phase   = 1'b0;
  logic       i_push_pull   = 1'b0;
  logic       i_status_req  = 1'b0;
  logic [3:0] i_status_bits = 4'h0;
  logic       rx_data;
  logic       rx_strobe;
  logic       pend;
  logic       tx_d;
  logic       tx_d_oe_n;
  logic       tx_s;
  logic       tx_s_oe_n;
  logic [1:0] ctl;
  logic [3:0] dat;
  logic [3:0] stat_bits;
  logic [3:0] exp_q[$];
  logic       d_lvl = 1'b0;
  logic       s_lvl = 1'b0;
  logic       pp    = 1'b0;
  logic       tx_on = 1'b0;
  int         miscompares = 0;
  int         tests_run   = 0;
  int         pidx = 0;
  int         sidx = 0;
  int         stat_done = 0;
  int         stat_reqs = 0;

  always #50 i_ref_clk = ~i_ref_clk;

  initial
  begin
    #7;
    forever #24 i_bus_clk = ~i_bus_clk;
  end

  // Slow grouping is tied off: at this bus clock its messages come too close
  bpr_rx_path DUT (
    .i_ref_clk            (i_ref_clk),
    .i_resetn             (i_resetn),
    .i_bus_clk            (i_bus_clk),
    .i_rx_bus_data        (rx_data),
    .i_rx_bus_strobe      (rx_strobe),
    .i_fast_rate          (1'b1),
    .i_tx_valid           (i_tx_valid),
    .i_tx_bit             (i_tx_bit),
    .i_arb_phase          (i_arb_phase),
    .i_push_pull          (i_push_pull),
    .o_tx_bus_data        (tx_d),
    .o_tx_bus_data_oe_n   (tx_d_oe_n),
    .o_tx_bus_strobe      (tx_s),
    .o_tx_bus_strobe_oe_n (tx_s_oe_n),
    .i_status_req         (i_status_req),
    .i_status_bits        (i_status_bits),
    .o_status_pending     (pend),
    .o_link_control_pair  (ctl),
    .o_link_data          (dat)
  );

  bpr_bus_src SRC (
    .i_bus_clk (i_bus_clk),
    .o_data    (rx_data),
    .o_strobe  (rx_strobe)
  );

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Full nibbles avoid all ones, which is the resting level between symbols
  task automatic send_pkt;
    bit         bits[$];
    logic [3:0] n;
    int         full;
    int         tail;
    full = 1 + $urandom % 3;
    tail = 2 + $urandom % 2;
    for (int k = 0; k <= full; k++)
    begin
      n = 4'($urandom);
      while (k < full && n == 4'hf)
        n = 4'($urandom);
      if (k == full)
        n = n & ((4'h1 << tail) - 4'h1);
      exp_q.push_back(n);
      for (int b = 0; b < (k < full ? 4 : tail); b++)
        bits.push_back(n[b]);
    end
    SRC.send(bits);
  endtask

  task automatic status_req;
    logic [3:0] r;
    r = 4'($urandom);
    @(posedge i_ref_clk);
    i_status_req  <= 1'b1;
    i_status_bits <= r;
    stat_bits = r;
    stat_reqs++;
    @(posedge i_ref_clk);
    i_status_req <= 1'b0;
    @(posedge i_ref_clk);
    check({3'h0, pend}, 4'h1);
  endtask

  ////////////////////////////////////////////////////////////
  always @(posedge i_ref_clk)
  begin
    if (i_resetn && ctl === bpr_pkg::CTL_RECEIVE)
    begin
      if (pidx == 0)
        check(dat, bpr_pkg::D_ALL_HIGH);
      else if (pidx == 1)
        check(dat, {bpr_pkg::D_UPPER_LOW, bpr_pkg::SPEED_CODE});
      else if (dat !== 4'hf)
        check(dat, exp_q.size() ? exp_q.pop_front() : 4'hx);
      pidx++;
      sidx = 0;
    end
    else if (i_resetn && ctl === bpr_pkg::CTL_STATUS)
    begin
      check(dat, {2'h0, stat_bits[2 * sidx +: 2]});
      sidx++;
    end
    else if (i_resetn)
    begin
      if (pidx > 0)
        check(4'(exp_q.size()), 4'h0);
      // A transfer cut by a packet is sent again, so only one closed by idle counts
      stat_done += (sidx == 2);
      pidx = 0;
      sidx = 0;
    end
  end

  // Expected pin pair {value, enable_n}; value is masked while released
  function automatic logic [1:0] pin_exp(input logic lvl, input logic drv);
    pin_exp = lvl ? 2'h0 : (drv ? 2'h2 : 2'h1);
  endfunction

  wire [3:0] tx_seen = {tx_d_oe_n ? 1'b0 : tx_d, tx_d_oe_n, tx_s_oe_n ? 1'b0 : tx_s, tx_s_oe_n};

  always @(posedge i_bus_clk)
  begin
    if (tx_on)
    begin
      if (i_tx_valid && i_tx_bit != d_lvl)
        d_lvl = i_tx_bit;
      else if (i_tx_valid)
        s_lvl = ~s_lvl;
      pp = i_push_pull && !i_arb_phase;
      i_tx_valid  <= 1'($urandom);
      i_tx_bit    <= 1'($urandom);
      i_arb_phase <= ($urandom % 4) == 0;
      i_push_pull <= 1'($urandom);
    end
  end

  always @(negedge i_bus_clk)
  begin
    if (tx_on)
      check(tx_seen, {pin_exp(d_lvl, pp), pin_exp(s_lvl, pp)});
  end

  ////////////////////////////////////////////////////////////
  // Status requests slide across the packet start to hit pre-emption
  initial
  begin
    void'($urandom(32'h04a82570));
    repeat (12) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    @(posedge i_bus_clk);
    tx_on <= 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      fork
        send_pkt();
        begin
          repeat (i) @(posedge i_ref_clk);
          status_req();
        end
      join
      repeat (30) @(posedge i_ref_clk);
      check({3'h0, pend}, 4'h0);
    end
    check(4'(stat_done), 4'(stat_reqs));
    finish_test();
  end

  // Ten rounds of about 45 reference clocks each, with wide margin
  initial
  begin
    #200000;
    miscompares++;
    finish_test();
  end
endmodule // tb
